// *** hw/lpt_pkg.sv ***
package lpt_pkg;

  // lane geometry
  localparam int LANE_COUNT = 3;
  localparam int SLOT_COUNT = 7;
  localparam int COLOR_BITS = 6;
  localparam int PIXEL_BITS = 21;

  // clock and timing
  localparam int REF_CLK_MHZ = 200;
  localparam int LOCK_TIME_US = 10000;
  localparam int LOCK_CYCLES = LOCK_TIME_US * REF_CLK_MHZ;
  localparam int PD_DELAY_NS = 100;
  localparam int PD_DELAY_CYCLES = (PD_DELAY_NS * REF_CLK_MHZ) / 1000;
  localparam int LOSS_TIME_NS = 1000;
  localparam int LOSS_CYCLES = (LOSS_TIME_NS * REF_CLK_MHZ) / 1000;

  // reset values and fixed patterns
  localparam logic [2:0] SLOT_FIRST = 3'h0;
  localparam logic [2:0] SLOT_LAST = 3'h6;
  localparam logic [6:0] FWD_CLK_PATTERN = 7'h63;
  localparam logic [1:0] SYNC_RESET = 2'h0;

  typedef struct packed {
    logic [COLOR_BITS-1:0] red;
    logic [COLOR_BITS-1:0] green;
    logic [COLOR_BITS-1:0] blue;
    logic lineSync;
    logic frameSync;
    logic pixelDataValid;
  } lpt_pixel_type;

  typedef logic [LANE_COUNT-1:0][SLOT_COUNT-1:0] lpt_lanes_type;

  typedef struct packed {
    logic [LANE_COUNT-1:0] laneP;
    logic [LANE_COUNT-1:0] laneN;
    logic [LANE_COUNT-1:0] laneOe;
  } lpt_serial_type;

  typedef enum logic [2:0] {
    LK_IDLE = 3'b001,
    LK_ACQUIRE = 3'b010,
    LK_LOCKED = 3'b100
  } lpt_lock_type;

endpackage

// *** hw/lpt_serializer_tx.sv ***
`timescale 1ns/1ps
`default_nettype none

module lpt_serializer_tx #(
  parameter int LOCK_CYCLES = lpt_pkg::LOCK_CYCLES,
  parameter int LOSS_CYCLES = lpt_pkg::LOSS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic pixelClockInput,
  input wire lpt_pkg::lpt_pixel_type parallelPixelInputs,
  input wire logic strobeEdgeSelect,
  input wire logic powerDownN,
  output lpt_pkg::lpt_serial_type serialLaneOutputs,
  output logic forwardedClockOutputP,
  output logic forwardedClockOutputN,
  output logic forwardedClockOutputOe,
  output logic pllLocked
);

  // slot 0 is sent first; lane 2 carries the control lines in its top slots
  function automatic lpt_pkg::lpt_lanes_type mapSlots(input lpt_pkg::lpt_pixel_type px);
    lpt_pkg::lpt_lanes_type lanes;
    lanes[0] = {px.green[0], px.red};
    lanes[1] = {px.blue[1:0], px.green[5:1]};
    lanes[2] = {px.pixelDataValid, px.frameSync, px.lineSync, px.blue[5:2]};
    return lanes;
  endfunction

  // bit for the coming slot; forced low while unlocked
  function automatic logic slotBit(input logic [6:0] word, input logic [2:0] slot, input logic live);
    return live & word[slot];
  endfunction

  // power down acts as a reset of every domain
  wire logic asyncRstN;
  assign asyncRstN = nrst & powerDownN;

  // ---------------- pixel clock domain ----------------
  logic [1:0] rstPixSync_q;
  wire logic rstPixN;

  always_ff @(posedge pixelClockInput or negedge asyncRstN) begin
    if (!asyncRstN) begin
      rstPixSync_q <= lpt_pkg::SYNC_RESET;
    end else begin
      rstPixSync_q <= {rstPixSync_q[0], 1'b1};
    end
  end
  assign rstPixN = rstPixSync_q[1];

  lpt_pkg::lpt_pixel_type fallCap_q;
  lpt_pkg::lpt_pixel_type riseCap_q;

  always_ff @(negedge pixelClockInput or negedge rstPixN) begin
    if (!rstPixN) begin
      fallCap_q <= '0;
    end else begin
      fallCap_q <= parallelPixelInputs;
    end
  end

  always_ff @(posedge pixelClockInput or negedge rstPixN) begin
    if (!rstPixN) begin
      riseCap_q <= '0;
    end else begin
      riseCap_q <= parallelPixelInputs;
    end
  end

  // the select pin is static in use; synced so a late change cannot split a word
  logic [1:0] edgeSync_q;

  always_ff @(posedge pixelClockInput or negedge rstPixN) begin
    if (!rstPixN) begin
      edgeSync_q <= lpt_pkg::SYNC_RESET;
    end else begin
      edgeSync_q <= {edgeSync_q[0], strobeEdgeSelect};
    end
  end

  // heartbeat toggles every pixel period so the reference side can see the clock run
  logic beat_q;

  always_ff @(posedge pixelClockInput or negedge rstPixN) begin
    if (!rstPixN) begin
      beat_q <= 1'b0;
    end else begin
      beat_q <= ~beat_q;
    end
  end

  // word handshake: mailbox holds still until the reference side echoes the toggle
  // cost: a word captured while the handshake is busy is dropped, so
  // at least two words in three are lost at any pixel rate
  logic reqT_q;
  logic ackT_q;
  logic [1:0] ackSync_q;
  lpt_pkg::lpt_lanes_type mailbox_q;

  always_ff @(posedge pixelClockInput or negedge rstPixN) begin
    if (!rstPixN) begin
      ackSync_q <= lpt_pkg::SYNC_RESET;
    end else begin
      ackSync_q <= {ackSync_q[0], ackT_q};
    end
  end

  always_ff @(posedge pixelClockInput or negedge rstPixN) begin
    if (!rstPixN) begin
      reqT_q <= 1'b0;
      mailbox_q <= '0;
    end else if (ackSync_q[1] == reqT_q) begin
      // low select (pull-down default) takes the falling-edge copy
      mailbox_q <= edgeSync_q[1] ? mapSlots(riseCap_q) : mapSlots(fallCap_q);
      reqT_q <= ~reqT_q;
    end
  end

  // ---------------- reference clock domain ----------------
  logic [1:0] rstRefSync_q;
  wire logic rstRefN;

  always_ff @(posedge ref_clk or negedge asyncRstN) begin
    if (!asyncRstN) begin
      rstRefSync_q <= lpt_pkg::SYNC_RESET;
    end else begin
      rstRefSync_q <= {rstRefSync_q[0], 1'b1};
    end
  end
  assign rstRefN = rstRefSync_q[1];

  logic [1:0] beatSync_q;
  logic beatLast_q;
  wire logic beatEdge;

  always_ff @(posedge ref_clk or negedge rstRefN) begin
    if (!rstRefN) begin
      beatSync_q <= lpt_pkg::SYNC_RESET;
      beatLast_q <= 1'b0;
    end else begin
      beatSync_q <= {beatSync_q[0], beat_q};
      beatLast_q <= beatSync_q[1];
    end
  end
  assign beatEdge = beatSync_q[1] ^ beatLast_q;

  // lock tracker: the lock counter only needs a steady heartbeat, so slow
  // spread-spectrum wander never looks like a lost clock
  lpt_pkg::lpt_lock_type lock_q;
  logic [31:0] lockCnt_q;
  logic [31:0] idleCnt_q;

  always_ff @(posedge ref_clk or negedge rstRefN) begin
    if (!rstRefN) begin
      idleCnt_q <= '0;
    end else if (beatEdge) begin
      idleCnt_q <= '0;
    end else if (idleCnt_q < 32'(LOSS_CYCLES)) begin
      idleCnt_q <= idleCnt_q + 32'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstRefN) begin
    if (!rstRefN) begin
      lock_q <= lpt_pkg::LK_IDLE;
      lockCnt_q <= '0;
    end else begin
      case (lock_q)
        lpt_pkg::LK_IDLE: begin
          lockCnt_q <= '0;
          if (beatEdge) begin
            lock_q <= lpt_pkg::LK_ACQUIRE;
          end
        end
        lpt_pkg::LK_ACQUIRE: begin
          if (idleCnt_q >= 32'(LOSS_CYCLES)) begin
            lock_q <= lpt_pkg::LK_IDLE;
          end else if (lockCnt_q >= 32'(LOCK_CYCLES - 1)) begin
            lock_q <= lpt_pkg::LK_LOCKED;
          end else begin
            lockCnt_q <= lockCnt_q + 32'h1;
          end
        end
        lpt_pkg::LK_LOCKED: begin
          if (idleCnt_q >= 32'(LOSS_CYCLES)) begin
            lock_q <= lpt_pkg::LK_IDLE;
          end
        end
        default: begin
          lock_q <= lpt_pkg::LK_IDLE;
        end
      endcase
    end
  end

  // word receive side of the handshake
  logic [1:0] reqSync_q;
  logic reqSeen_q;
  logic pendValid_q;
  lpt_pkg::lpt_lanes_type pend_q;
  wire logic newWord;

  always_ff @(posedge ref_clk or negedge rstRefN) begin
    if (!rstRefN) begin
      reqSync_q <= lpt_pkg::SYNC_RESET;
    end else begin
      reqSync_q <= {reqSync_q[0], reqT_q};
    end
  end
  assign newWord = reqSync_q[1] != reqSeen_q;

  always_ff @(posedge ref_clk or negedge rstRefN) begin
    if (!rstRefN) begin
      reqSeen_q <= 1'b0;
      ackT_q <= 1'b0;
      pend_q <= '0;
    end else if (newWord) begin
      pend_q <= mailbox_q;
      reqSeen_q <= reqSync_q[1];
      ackT_q <= reqSync_q[1];
    end
  end

  logic [2:0] slot_q;
  lpt_pkg::lpt_lanes_type shift_q;
  wire logic loadSlot;
  wire logic isLocked;

  assign isLocked = lock_q == lpt_pkg::LK_LOCKED;
  assign loadSlot = isLocked && slot_q == lpt_pkg::SLOT_LAST;

  // a word arriving on the load cycle stays pending: set wins over clear
  always_ff @(posedge ref_clk or negedge rstRefN) begin
    if (!rstRefN) begin
      pendValid_q <= 1'b0;
    end else if (newWord) begin
      pendValid_q <= 1'b1;
    end else if (loadSlot) begin
      pendValid_q <= 1'b0;
    end
  end

  // slot counter and word shifter; with no fresh word the last one repeats
  always_ff @(posedge ref_clk or negedge rstRefN) begin
    if (!rstRefN) begin
      slot_q <= lpt_pkg::SLOT_FIRST;
      shift_q <= '0;
    end else if (!isLocked) begin
      slot_q <= lpt_pkg::SLOT_FIRST;
    end else if (loadSlot) begin
      slot_q <= lpt_pkg::SLOT_FIRST;
      if (pendValid_q && !newWord) begin
        shift_q <= pend_q;
      end
    end else begin
      slot_q <= slot_q + 3'h1;
    end
  end

  // per-lane bit for the coming slot
  wire logic [lpt_pkg::LANE_COUNT-1:0] laneBit;
  wire logic fwdBit;

  for (genvar g = 0; g < lpt_pkg::LANE_COUNT; g++) begin : g_lane
    assign laneBit[g] = slotBit(shift_q[g], slot_q, isLocked);
  end
  assign fwdBit = slotBit(lpt_pkg::FWD_CLK_PATTERN, slot_q, isLocked);

  // output stage; reset is asynchronous so disable follows power down at once
  lpt_pkg::lpt_serial_type serial_q;
  logic fwdP_q;
  logic fwdOe_q;
  logic locked_q;

  always_ff @(posedge ref_clk or negedge asyncRstN) begin
    if (!asyncRstN) begin
      serial_q <= '0;
      fwdP_q <= 1'b0;
      fwdOe_q <= 1'b0;
    end else if (!rstRefN) begin
      serial_q <= '0;
      fwdP_q <= 1'b0;
      fwdOe_q <= 1'b0;
    end else begin
      fwdOe_q <= 1'b1;
      serial_q.laneOe <= '1;
      // missing clock pulls every pair to logic low
      fwdP_q <= fwdBit;
      serial_q.laneP <= laneBit;
      serial_q.laneN <= ~laneBit;
    end
  end

  // lock flag; the lock state is itself held idle while reset is synced out
  always_ff @(posedge ref_clk or negedge asyncRstN) begin
    if (!asyncRstN) begin
      locked_q <= 1'b0;
    end else begin
      locked_q <= isLocked;
    end
  end

  logic fwdN_q;

  always_ff @(posedge ref_clk or negedge asyncRstN) begin
    if (!asyncRstN) begin
      fwdN_q <= 1'b0;
    end else if (!rstRefN) begin
      fwdN_q <= 1'b0;
    end else begin
      fwdN_q <= ~fwdBit;
    end
  end

  assign serialLaneOutputs = serial_q;
  assign forwardedClockOutputP = fwdP_q;
  assign forwardedClockOutputN = fwdN_q;
  assign forwardedClockOutputOe = fwdOe_q;
  assign pllLocked = locked_q;

endmodule

`default_nettype wire

// *** tb/lpt_serializer_tx_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module lpt_serializer_tx_sva #(
  parameter int LOCK_CYCLES = 50,
  parameter int LOSS_CYCLES = 20
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic pixelClockInput,
  input wire lpt_pkg::lpt_pixel_type parallelPixelInputs,
  input wire logic strobeEdgeSelect,
  input wire logic powerDownN,
  input wire lpt_pkg::lpt_serial_type serialLaneOutputs,
  input wire logic forwardedClockOutputP,
  input wire logic forwardedClockOutputN,
  input wire logic forwardedClockOutputOe,
  input wire logic pllLocked
);
  logic [6:0] fwdHist_q;
  logic [15:0] idleCnt_q;
  logic [15:0] onCnt_q;
  logic pixSeen_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  always_ff @(posedge ref_clk) fwdHist_q <= {fwdHist_q[5:0], forwardedClockOutputP};
  // ref cycles since the pixel clock last moved
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      idleCnt_q <= 16'h0;
      pixSeen_q <= 1'b0;
    end else begin
      pixSeen_q <= pixelClockInput;
      if (pixelClockInput != pixSeen_q) idleCnt_q <= 16'h0;
      else if (idleCnt_q != 16'hffff) idleCnt_q <= idleCnt_q + 16'h1;
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) onCnt_q <= 16'h0;
    else if (!forwardedClockOutputOe) onCnt_q <= 16'h0;
    else if (onCnt_q != 16'hffff) onCnt_q <= onCnt_q + 16'h1;
  end
  sequence s_held_off;
    (!forwardedClockOutputOe)[*3];
  endsequence
  sequence s_enabled;
    forwardedClockOutputOe || !powerDownN;
  endsequence
  a_pd_outputs_off: assert property (!powerDownN |->
    serialLaneOutputs.laneOe == 3'h0 && !forwardedClockOutputOe && !pllLocked) else $error("outputs live in power down");
  a_release_on: assert property ($rose(powerDownN) |-> s_held_off ##1 s_enabled)
    else $error("output enable timing after release wrong");
  a_lane_diff: assert property (serialLaneOutputs.laneOe == 3'h7 |->
    serialLaneOutputs.laneN == ~serialLaneOutputs.laneP) else $error("lane pair not complementary");
  a_fwd_diff: assert property (forwardedClockOutputOe |-> forwardedClockOutputN == !forwardedClockOutputP)
    else $error("clock pair not complementary");
  a_oe_together: assert property (serialLaneOutputs.laneOe == {3{forwardedClockOutputOe}})
    else $error("enables disagree");
  a_idle_low: assert property ((forwardedClockOutputOe && !pllLocked) ##1 !pllLocked |->
    $past(serialLaneOutputs.laneP) == 3'h0) else $error("lanes toggle while unlocked");
  a_fwd_pattern: assert property (pllLocked && $past(pllLocked, 8) && $rose(forwardedClockOutputP) |->
    fwdHist_q == 7'h78) else $error("forwarded clock pattern wrong");
  a_lock_loss: assert property (idleCnt_q > 16'(LOSS_CYCLES + 12) |-> !pllLocked)
    else $error("lock held with pixel clock stopped");
  a_lock_time: assert property ($rose(pllLocked) |-> onCnt_q >= 16'(LOCK_CYCLES))
    else $error("lock reported too early");
endmodule
`default_nettype wire

// *** tb/lpt_rx_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module lpt_rx_model (
  input wire logic ref_clk,
  input wire lpt_pkg::lpt_serial_type lanes,
  input wire logic fwdP,
  input wire logic fwdOe,
  output lpt_pkg::lpt_pixel_type rxWord,
  output logic rxValid
);
  logic [2:0][6:0] sh;
  logic [2:0][6:0] nx;
  logic [2:0] slot;
  logic [2:0] cur;
  logic prevFwd = 1'b0;
  // rising forwarded clock marks slot five
  always_comb begin
    cur = (fwdP && !prevFwd) ? 3'h5 : (slot == 3'h6) ? 3'h0 : slot + 3'h1;
    for (int i = 0; i < 3; i++) nx[i] = {lanes.laneP[i], sh[i][6:1]};
  end
  always_ff @(posedge ref_clk) begin
    prevFwd <= fwdP;
    slot <= cur;
    sh <= nx;
    rxValid <= fwdOe && cur == 3'h6 && lanes.laneOe == 3'h7;
    rxWord <= {nx[0][5:0], nx[1][4:0], nx[0][6], nx[2][3:0], nx[1][6:5], nx[2][4], nx[2][5], nx[2][6]};
  end
endmodule
`default_nettype wire

// *** tb/lvds_pixel_serializer_tx_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(name, exp, got) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      n_fail++; \
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got); \
    end \
  end
module lvds_pixel_serializer_tx_bench;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic pixClk = 1'b0;
  logic pixRun = 1'b0;
  realtime pixHalf = 7.5;
  lpt_pkg::lpt_pixel_type pix = '0;
  lpt_pkg::lpt_pixel_type wA = '0;
  lpt_pkg::lpt_pixel_type wB = '0;
  lpt_pkg::lpt_pixel_type rxWord;
  lpt_pkg::lpt_serial_type lanes;
  logic sel = 1'b0;
  logic pdN = 1'b1;
  logic fwdP, fwdN, fwdOe, locked, rxValid;
  int n_fail = 0;
  int n_checks = 0;
  initial forever #2.5 ref_clk = ~ref_clk;
  // pixel clock stands still while stopped
  initial begin
    #1.3;
    forever begin
      if (pixRun) pixClk = ~pixClk;
      #(pixHalf);
    end
  end
  // wB is seen around falling edges, wA around rising ones
  always @(posedge pixClk) pix <= #(pixHalf / 2) wB;
  always @(negedge pixClk) pix <= #(pixHalf / 2) wA;
  lpt_serializer_tx #(.LOCK_CYCLES(50), .LOSS_CYCLES(20)) uut (
    .ref_clk(ref_clk), .nrst(nrst), .pixelClockInput(pixClk), .parallelPixelInputs(pix),
    .strobeEdgeSelect(sel), .powerDownN(pdN), .serialLaneOutputs(lanes), .forwardedClockOutputP(fwdP),
    .forwardedClockOutputN(fwdN), .forwardedClockOutputOe(fwdOe), .pllLocked(locked)
  );
  lpt_rx_model rx (.ref_clk(ref_clk), .lanes(lanes), .fwdP(fwdP), .fwdOe(fwdOe), .rxWord(rxWord), .rxValid(rxValid));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wait_lock;
    int k;
    k = 0;
    while (locked !== 1'b1 && k < 400) begin
      @(negedge ref_clk);
      k++;
    end
    `CHK("pllLocked", 1'b1, locked)
  endtask
  // older words may still be in flight, so skip until a match
  task automatic expect_word(input lpt_pkg::lpt_pixel_type exp, input string name);
    int k;
    k = 0;
    do begin
      @(negedge ref_clk);
      if (rxValid === 1'b1) k++;
    end while (!(rxValid === 1'b1 && rxWord === exp) && k < 30);
    `CHK(name, exp, rxWord)
  endtask
  task automatic t_lock;
    pixRun = 1'b1;
    wait_lock();
    $display("t_lock done");
  endtask
  task automatic t_map;
    for (int b = 0; b < 21; b++) begin
      wA = 21'h1 << b;
      wB = wA;
      expect_word(21'h1 << b, "walking bit");
    end
    $display("t_map done");
  endtask
  task automatic t_edge;
    for (int s = 0; s < 2; s++) begin
      @(negedge ref_clk);
      sel = s[0];
      wA = 21'h0aaaaa;
      wB = 21'h155555;
      expect_word(s ? wA : wB, "strobe edge");
    end
    $display("t_edge done");
  endtask
  task automatic t_stop;
    pixRun = 1'b0;
    repeat (60) @(negedge ref_clk);
    `CHK("pllLocked", 1'b0, locked)
    `CHK("laneP", 3'h0, lanes.laneP)
    pixHalf = 7.8;
    wA = 21'h12345;
    wB = wA;
    pixRun = 1'b1;
    wait_lock();
    expect_word(21'h12345, "after restart");
    $display("t_stop done");
  endtask
  task automatic t_pd;
    @(negedge ref_clk);
    pdN = 1'b0;
    #1;
    `CHK("laneOe", 3'h0, lanes.laneOe)
    `CHK("fwdOe", 1'b0, fwdOe)
    `CHK("pllLocked", 1'b0, locked)
    pixRun = 1'b0;
    repeat (200) @(negedge ref_clk);
    pixRun = 1'b1;
    wA = 21'h0f0f0;
    wB = wA;
    repeat (20) @(negedge ref_clk);
    `CHK("laneOe held", 3'h0, lanes.laneOe)
    pdN = 1'b1;
    wait_lock();
    expect_word(21'h0f0f0, "after power down");
    $display("t_pd done");
  endtask
  initial begin
    repeat (20) @(negedge ref_clk);
    nrst = 1'b1;
    t_lock();
    t_map();
    t_edge();
    t_stop();
    t_pd();
    complete_run();
  end
  initial begin
    #300000;
    n_fail++;
    complete_run();
  end
endmodule
bind lpt_serializer_tx lpt_serializer_tx_sva #(.LOCK_CYCLES(LOCK_CYCLES), .LOSS_CYCLES(LOSS_CYCLES)) chk (
  .ref_clk, .nrst, .pixelClockInput, .parallelPixelInputs, .strobeEdgeSelect, .powerDownN,
  .serialLaneOutputs, .forwardedClockOutputP, .forwardedClockOutputN, .forwardedClockOutputOe, .pllLocked
);
`default_nettype wire
